//--- src/ccidbe_pkg.sv
package ccidbe_pkg;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int DATA_W = 8;
	localparam int ADDR_W = 7;
	localparam int PC_W = 13;
	localparam int IMM_W = 11;
	localparam int INSTR_W = 14;
	localparam int LIT_W = 8;

	// ----------------------------------------------------------------
	// instruction word fields
	// ----------------------------------------------------------------
	localparam int OPC_HI = 13;
	localparam int OPC_LO = 8;
	localparam int BR_OPC_LO = 11;
	localparam int DEST_BIT = 7;
	localparam logic [5:0] OPC_CLEAR = 6'h01;
	localparam logic [5:0] OPC_DECREMENT = 6'h03;
	localparam logic [5:0] OPC_DEC_SKIP = 6'h0B;
	localparam logic [5:0] OPC_INC_SKIP = 6'h0F;
	localparam logic [5:0] OPC_OR_LITERAL = 6'h38;
	localparam logic [2:0] OPC_BRANCH = 3'h5;

	// ----------------------------------------------------------------
	// page bits taken from the high latch
	// ----------------------------------------------------------------
	localparam int LATCH_W = 8;
	localparam int PAGE_HI = 4;
	localparam int PAGE_LO = 3;

	// ----------------------------------------------------------------
	// constants and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam logic [7:0] ONE_BYTE = 8'h01;
	localparam logic [7:0] W_RESET = 8'h00;
	localparam logic Z_RESET = 1'b0;
	localparam logic [12:0] PC_RESET = 13'h0000;
	localparam logic [12:0] PC_STEP = 13'h0001;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		OP_NOP = 3'b000,
		OP_CLEAR_FILE = 3'b001,
		OP_CLEAR_WORKING = 3'b010,
		OP_DECREMENT = 3'b011,
		OP_DEC_SKIP = 3'b100,
		OP_INC_SKIP = 3'b101,
		OP_BRANCH = 3'b110,
		OP_OR_LITERAL = 3'b111
	} ccidbe_op_t;

	typedef enum logic {
		ST_EXEC = 1'b0,
		ST_FLUSH = 1'b1
	} ccidbe_state_t;

	typedef struct packed {
		ccidbe_op_t op;
		logic dest;
		logic [6:0] faddr;
		logic [10:0] imm;
	} ccidbe_dec_t;

	typedef struct packed {
		logic en;
		logic [6:0] addr;
		logic [7:0] data;
	} ccidbe_fwr_t;

endpackage : ccidbe_pkg

//--- src/ccidbe_alu.sv
`timescale 1ns/1ps
module ccidbe_alu (
	input ccidbe_pkg::ccidbe_op_t op,
	input wire logic [7:0] file_val,
	input wire logic [7:0] working,
	input wire logic [7:0] literal,
	output logic [7:0] result,
	output logic zero
);
	import ccidbe_pkg::*;

	// ----------------------------------------------------------------
	// result and zero detect
	// ----------------------------------------------------------------
	always_comb begin
		unique case (op)
			OP_CLEAR_FILE: result = ZERO_BYTE;
			OP_CLEAR_WORKING: result = ZERO_BYTE;
			OP_DECREMENT: result = 8'(file_val - ONE_BYTE);
			OP_DEC_SKIP: result = 8'(file_val - ONE_BYTE);
			OP_INC_SKIP: result = 8'(file_val + ONE_BYTE);
			OP_OR_LITERAL: result = working | literal;
			OP_BRANCH: result = file_val;
			OP_NOP: result = file_val;
		endcase
	end

	assign zero = (result == ZERO_BYTE);

endmodule : ccidbe_alu

//--- src/ccidbe_exec.sv
`timescale 1ns/1ps
// Overview of operation
// - clear-file writes zero to the addressed register and sets zero flag
// - decrement stores file minus one to W (d=0) or file (d=1), updates zero
// - clear-working loads zero into W and sets zero flag
// - decrement-skip stores per d, status untouched, zero result flushes next cycle
// - increment-skip stores per d, status untouched, zero result flushes next cycle
// - branch loads immediate into pc 10:0 and latch bits 4:3 into pc 12:11
// - branch immediate is eleven bits wide, 0 to 2047
// - or-literal ors eight-bit literal into W and updates zero flag
// - branch takes two instruction cycles
module ccidbe_exec #(
	parameter int DATA_WIDTH = ccidbe_pkg::DATA_W,
	parameter int PC_WIDTH = ccidbe_pkg::PC_W
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic instr_valid,
	input wire logic [ccidbe_pkg::INSTR_W-1:0] instr_word,
	input wire logic [ccidbe_pkg::LATCH_W-1:0] pc_high_latch,
	input wire logic [ccidbe_pkg::DATA_W-1:0] file_rd_data,
	output logic [ccidbe_pkg::ADDR_W-1:0] file_rd_addr,
	output ccidbe_pkg::ccidbe_fwr_t file_wr,
	output logic [ccidbe_pkg::DATA_W-1:0] working_reg,
	output logic zero_flag_reg,
	output logic [ccidbe_pkg::PC_W-1:0] pc_reg,
	output logic flush_cycle
);
	import ccidbe_pkg::*;

	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------
	if (DATA_WIDTH != DATA_W || PC_WIDTH != PC_W) begin : g_bad_width
		$error("ccidbe_exec: only 8-bit data and 13-bit pc are supported");
	end

	ccidbe_state_t state_reg;
	ccidbe_state_t state_next;
	ccidbe_dec_t dec;
	ccidbe_fwr_t wr_next;
	logic flush_skip_reg;
	logic exec;
	logic [7:0] rd_fwd;
	logic [7:0] alu_res;
	logic alu_zero;
	logic skip_op;
	logic [12:0] branch_target;

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	always_comb begin
		dec.op = OP_NOP;
		dec.dest = instr_word[DEST_BIT];
		dec.faddr = instr_word[ADDR_W-1:0];
		dec.imm = instr_word[IMM_W-1:0];
		if (instr_word[OPC_HI:BR_OPC_LO] == OPC_BRANCH) begin
			dec.op = OP_BRANCH;
		end else begin
			unique case (instr_word[OPC_HI:OPC_LO])
				OPC_CLEAR: dec.op = dec.dest ? OP_CLEAR_FILE : OP_CLEAR_WORKING;
				OPC_DECREMENT: dec.op = OP_DECREMENT;
				OPC_DEC_SKIP: dec.op = OP_DEC_SKIP;
				OPC_INC_SKIP: dec.op = OP_INC_SKIP;
				OPC_OR_LITERAL: dec.op = OP_OR_LITERAL;
				default: dec.op = OP_NOP;
			endcase
		end
	end

	assign exec = (state_reg == ST_EXEC) && instr_valid;
	assign flush_cycle = (state_reg == ST_FLUSH);
	assign file_rd_addr = dec.faddr;
	assign skip_op = (dec.op == OP_DEC_SKIP) || (dec.op == OP_INC_SKIP);
	assign branch_target = {pc_high_latch[PAGE_HI:PAGE_LO], dec.imm};

	// pending write forwarded to a read of the same register
	assign rd_fwd = (file_wr.en && file_wr.addr == dec.faddr) ? file_wr.data : file_rd_data;

	ccidbe_alu u_alu (
		.op(dec.op),
		.file_val(rd_fwd),
		.working(working_reg),
		.literal(dec.imm[LIT_W-1:0]),
		.result(alu_res),
		.zero(alu_zero)
	);

	// ----------------------------------------------------------------
	// sequencing
	// ----------------------------------------------------------------
	always_comb begin
		state_next = ST_EXEC;
		if (exec && dec.op == OP_BRANCH) begin
			state_next = ST_FLUSH;
		end else if (exec && skip_op && alu_zero) begin
			state_next = ST_FLUSH;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_reg <= ST_EXEC;
			flush_skip_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			flush_skip_reg <= exec && skip_op;
		end
	end

	// ----------------------------------------------------------------
	// program counter
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pc_reg <= PC_RESET;
		end else if (exec && dec.op == OP_BRANCH) begin
			pc_reg <= branch_target;
		end else if (exec || (flush_cycle && flush_skip_reg)) begin
			pc_reg <= 13'(pc_reg + PC_STEP);
		end
	end

	// ----------------------------------------------------------------
	// working register
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			working_reg <= W_RESET;
		end else if (exec) begin
			unique case (dec.op)
				OP_CLEAR_WORKING: working_reg <= ZERO_BYTE;
				OP_OR_LITERAL: working_reg <= alu_res;
				OP_DECREMENT, OP_DEC_SKIP, OP_INC_SKIP: begin
					if (!dec.dest) begin
						working_reg <= alu_res;
					end
				end
				OP_NOP, OP_CLEAR_FILE, OP_BRANCH: working_reg <= working_reg;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// zero flag
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			zero_flag_reg <= Z_RESET;
		end else if (exec) begin
			unique case (dec.op)
				OP_CLEAR_FILE, OP_CLEAR_WORKING: zero_flag_reg <= 1'b1;
				OP_DECREMENT, OP_OR_LITERAL: zero_flag_reg <= alu_zero;
				OP_NOP, OP_DEC_SKIP, OP_INC_SKIP, OP_BRANCH: zero_flag_reg <= zero_flag_reg;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// file register write
	// ----------------------------------------------------------------
	always_comb begin
		wr_next.addr = dec.faddr;
		wr_next.data = alu_res;
		wr_next.en = 1'b0;
		if (exec) begin
			unique case (dec.op)
				OP_CLEAR_FILE: wr_next.en = 1'b1;
				OP_DECREMENT, OP_DEC_SKIP, OP_INC_SKIP: wr_next.en = dec.dest;
				OP_NOP, OP_CLEAR_WORKING, OP_BRANCH, OP_OR_LITERAL: wr_next.en = 1'b0;
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			file_wr <= '0;
		end else begin
			file_wr <= wr_next;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence s_dec_skip_hit;
		exec && dec.op == OP_DEC_SKIP && rd_fwd == ONE_BYTE;
	endsequence

	sequence s_inc_skip_hit;
		exec && dec.op == OP_INC_SKIP && rd_fwd == 8'hFF;
	endsequence

	sequence s_flush_once;
		flush_cycle ##1 !flush_cycle;
	endsequence

	a_clear_file_op: assert property (exec && dec.op == OP_CLEAR_FILE |=>
		file_wr.en && file_wr.data == ZERO_BYTE && file_wr.addr == $past(dec.faddr) && zero_flag_reg)
		else $error("clear-file did not zero the register and set zero");

	a_decrement_dest: assert property (exec && dec.op == OP_DECREMENT |=>
		($past(dec.dest) ? (file_wr.en && file_wr.data == 8'($past(rd_fwd) - ONE_BYTE))
		: (!file_wr.en && working_reg == 8'($past(rd_fwd) - ONE_BYTE))))
		else $error("decrement result went to the wrong place");

	a_clear_working: assert property (exec && dec.op == OP_CLEAR_WORKING |=>
		working_reg == ZERO_BYTE && zero_flag_reg && !file_wr.en)
		else $error("clear-working did not clear W and set zero");

	a_dec_skip_flush: assert property (s_dec_skip_hit |=> s_flush_once ##0
		pc_reg == 13'($past(pc_reg, 2) + 13'h0002))
		else $error("decrement-skip did not discard the next instruction");

	a_dec_skip_status: assert property (exec && dec.op == OP_DEC_SKIP |=>
		$stable(zero_flag_reg))
		else $error("decrement-skip changed the zero flag");

	a_inc_skip_flush: assert property (s_inc_skip_hit |=> $stable(zero_flag_reg) ##0
		s_flush_once ##0 pc_reg == 13'($past(pc_reg, 2) + 13'h0002))
		else $error("increment-skip did not flush or changed status");

	a_no_skip_nonzero: assert property (exec && skip_op && !alu_zero |=>
		!flush_cycle)
		else $error("skip taken on a nonzero result");

	a_branch_target: assert property (exec && dec.op == OP_BRANCH |=>
		pc_reg == {$past(pc_high_latch[PAGE_HI:PAGE_LO]), $past(instr_word[IMM_W-1:0])}
		&& $stable(zero_flag_reg) && $stable(working_reg))
		else $error("branch target or status wrong");

	a_branch_two_cycle: assert property (exec && dec.op == OP_BRANCH |=>
		flush_cycle ##1 (!flush_cycle && $stable(pc_reg)))
		else $error("branch did not take two cycles");

	a_or_zero_flag: assert property (exec && dec.op == OP_OR_LITERAL |=>
		working_reg == ($past(working_reg) | $past(instr_word[LIT_W-1:0]))
		&& zero_flag_reg == (working_reg == ZERO_BYTE))
		else $error("or-literal result or zero flag wrong");

endmodule : ccidbe_exec

//--- dv/cpu_clear_inc_dec_branch_exec_tb.sv
`timescale 1ns/1ps
module cpu_clear_inc_dec_branch_exec_tb;
	import ccidbe_pkg::*;
	typedef struct {
		logic [7:0] w;
		logic z;
		logic [12:0] pc;
		logic en;
		logic [6:0] a;
		logic [7:0] d;
		logic fl;
	} ccidbe_exp_t;
	logic ref_clk;
	logic rst;
	logic instr_valid;
	logic [13:0] instr_word;
	logic [7:0] pc_high_latch;
	logic [7:0] file_rd_data;
	logic [6:0] file_rd_addr;
	ccidbe_fwr_t file_wr;
	logic [7:0] working_reg;
	logic zero_flag_reg;
	logic [12:0] pc_reg;
	logic flush_cycle;
	logic [7:0] fmem [128];
	logic [7:0] mmem [128];
	logic [7:0] w_m;
	logic z_m;
	logic [12:0] pc_m;
	logic taken_d;
	logic [13:0] wd;
	int k;
	int error_cnt;
	int cmp_count;
	int cyc;
	ccidbe_exp_t cur;
	ccidbe_exp_t exp_q[$];
	logic [5:0] opc_tbl [7] = '{OPC_CLEAR, OPC_DECREMENT, OPC_DEC_SKIP, OPC_INC_SKIP,
		OPC_OR_LITERAL, 6'h00, 6'h00};
	logic [13:0] dir_tbl [15] = '{14'h385A, 14'h0100, 14'h3800, 14'h38FF, 14'h01A0,
		14'h0320, 14'h0FA0, 14'h0BA0, 14'h03A0, 14'h0F20, 14'h0320, 14'h2800, 14'h2FFF,
		14'h2ABC, 14'h0100};

	ccidbe_exec u_dut (
		.ref_clk(ref_clk),
		.rst(rst),
		.instr_valid(instr_valid),
		.instr_word(instr_word),
		.pc_high_latch(pc_high_latch),
		.file_rd_data(file_rd_data),
		.file_rd_addr(file_rd_addr),
		.file_wr(file_wr),
		.working_reg(working_reg),
		.zero_flag_reg(zero_flag_reg),
		.pc_reg(pc_reg),
		.flush_cycle(flush_cycle)
	);

	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	// ----------------------------------------------------------------
	// file register array and result monitor
	// ----------------------------------------------------------------
	assign file_rd_data = fmem[file_rd_addr];
	always @(posedge ref_clk) begin
		if (file_wr.en === 1'b1) fmem[file_wr.addr] <= file_wr.data;
		taken_d <= !rst && instr_valid && !flush_cycle;
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			error_cnt++;
			final_report();
		end
	end
	always @(negedge ref_clk) begin
		if (taken_d) begin
			cur = exp_q.pop_front();
			chk("working_reg", cur.w, working_reg);
			chk("zero_flag_reg", cur.z, zero_flag_reg);
			chk("pc_reg", cur.pc, pc_reg);
			chk("flush_cycle", cur.fl, flush_cycle);
			chk("wr_en", cur.en, file_wr.en);
			if (cur.en) begin
				chk("wr_addr", cur.a, file_wr.addr);
				chk("wr_data", cur.d, file_wr.data);
			end
		end
	end

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH %s expected %0h seen %0h", nm, e, g);
		end
	endtask : chk

	task automatic idle();
		instr_valid <= 1'b0;
		instr_word <= 14'($urandom);
		@(posedge ref_clk);
	endtask : idle

	task automatic issue(input logic [13:0] w);
		ccidbe_exp_t e;
		logic [7:0] lat;
		logic [7:0] r;
		lat = 8'($urandom);
		e.en = 1'b0;
		e.a = w[6:0];
		e.d = 8'h00;
		e.fl = 1'b0;
		r = w_m;
		pc_m = pc_m + 13'h0001;
		if (w[13:11] == OPC_BRANCH) begin
			pc_m = {lat[4:3], w[10:0]};
			e.fl = 1'b1;
		end else begin
			case (w[13:8])
				OPC_CLEAR: r = 8'h00;
				OPC_DECREMENT, OPC_DEC_SKIP: r = mmem[w[6:0]] - 8'h01;
				OPC_INC_SKIP: r = mmem[w[6:0]] + 8'h01;
				OPC_OR_LITERAL: r = w_m | w[7:0];
				default: r = w_m;
			endcase
			if (w[13:8] inside {OPC_CLEAR, OPC_DECREMENT, OPC_DEC_SKIP, OPC_INC_SKIP}) begin
				if (w[7]) begin
					mmem[w[6:0]] = r;
					e.en = 1'b1;
					e.d = r;
				end else begin
					w_m = r;
				end
			end
			if (w[13:8] == OPC_OR_LITERAL) w_m = r;
			if (w[13:8] inside {OPC_DECREMENT, OPC_OR_LITERAL}) z_m = (r == 8'h00);
			if (w[13:8] == OPC_CLEAR) z_m = 1'b1;
			if (w[13:8] inside {OPC_DEC_SKIP, OPC_INC_SKIP}) e.fl = (r == 8'h00);
		end
		e.pc = pc_m;
		if (e.fl && w[13:11] != OPC_BRANCH) pc_m = pc_m + 13'h0001;
		e.w = w_m;
		e.z = z_m;
		exp_q.push_back(e);
		instr_valid <= 1'b1;
		instr_word <= w;
		pc_high_latch <= lat;
		@(posedge ref_clk);
		if (e.fl) begin
			instr_word <= 14'($urandom);
			pc_high_latch <= 8'($urandom);
			@(posedge ref_clk);
		end
	endtask : issue

	task final_report;
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : final_report

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		rst = 1'b1;
		instr_valid = 1'b0;
		instr_word = 14'h0000;
		pc_high_latch = 8'h00;
		taken_d = 1'b0;
		error_cnt = 0;
		cmp_count = 0;
		cyc = 0;
		w_m = 8'h00;
		z_m = 1'b0;
		pc_m = 13'h0000;
		void'($urandom(32'hB8D5));
		for (int i = 0; i < 128; i++) begin
			fmem[i] = 8'($urandom);
			mmem[i] = fmem[i];
		end
		repeat (12) @(posedge ref_clk);
		@(negedge ref_clk);
		chk("rst_w", 8'h00, working_reg);
		chk("rst_z", 1'b0, zero_flag_reg);
		chk("rst_pc", 13'h0000, pc_reg);
		chk("rst_flush", 1'b0, flush_cycle);
		chk("rst_wr_en", 1'b0, file_wr.en);
		@(posedge ref_clk);
		rst <= 1'b0;
		$display("test reset done");
		for (int i = 0; i < 15; i++) begin
			issue(dir_tbl[i]);
		end
		$display("test directed done");
		for (int i = 0; i < 300; i++) begin
			k = $urandom_range(6);
			if (k == 5) wd = {OPC_BRANCH, 11'($urandom)};
			else wd = {opc_tbl[k], 8'($urandom)};
			if ($urandom_range(3) == 0) idle();
			issue(wd);
		end
		idle();
		idle();
		chk("queue_left", 16'h0000, 16'(exp_q.size()));
		$display("test random done");
		final_report();
	end
endmodule : cpu_clear_inc_dec_branch_exec_tb
